/* File: hdl/scs_pkg.sv */
package scs_pkg;

   // clock source select codes, one per oscillator mode
   typedef enum logic [2:0] {
      SCS_MODE_LOW_POWER_CRYSTAL  = 3'h0,
      SCS_MODE_MEDIUM_GAIN_RESON  = 3'h1,
      SCS_MODE_HIGH_GAIN_RESON    = 3'h2,
      SCS_MODE_EXT_CLOCK_INPUT    = 3'h3,
      SCS_MODE_INT_RC_WITH_IO     = 3'h4,
      SCS_MODE_INT_RC_CLOCK_OUT   = 3'h5,
      SCS_MODE_EXT_RC_WITH_IO     = 3'h6,
      SCS_MODE_EXT_RC_CLOCK_OUT   = 3'h7
   } scs_mode_t;

   // startup counter states
   typedef enum logic [1:0] {
      SCS_ST_COUNT = 2'b00,
      SCS_ST_RUN   = 2'b01
   } scs_state_t;

   // register byte addresses
   localparam logic [11:0] SCS_ADDR_CONTROL = 12'h000;
   localparam logic [11:0] SCS_ADDR_TRIM    = 12'h004;
   localparam logic [11:0] SCS_ADDR_CONFIG  = 12'h008;

   // control field positions
   localparam int SCS_PS_LSB     = 4;
   localparam int SCS_LOCKED_BIT = 3;
   localparam int SCS_SETTLE_BIT = 2;
   localparam int SCS_TRIM_W     = 6;

   localparam logic [1:0] SCS_PS_RESET   = 2'h2;
   localparam logic [5:0] SCS_TRIM_RESET = 6'h00;

   // reference and locked frequencies in kHz
   localparam int SCS_REF_KHZ  = 500;
   localparam int SCS_PLL_KHZ  = 16000;
   localparam int SCS_PCLK_KHZ = 250000;
   // internal clock modelled as one tick per divide of pclk
   localparam int SCS_PLL_DIV  = SCS_PCLK_KHZ / (2 * SCS_PLL_KHZ);
   localparam int SCS_REF_DIV  = SCS_PCLK_KHZ / (2 * SCS_REF_KHZ);

   localparam int SCS_STARTUP_OSC = 1024;
   localparam int SCS_LOCK_CYCLES = 64;
   localparam int SCS_SETTLE_CYCLES = 256;

endpackage : scs_pkg

/* File: hdl/scs_clock_select.sv */
`timescale 1ns/1ns
// Contract
// (RULE1) eight oscillator modes chosen by a select field in configuration word
// (RULE2) external RC mode drives clock divided by four on second pin
// (RULE3) external RC with I/O releases second pin to general I/O
// (RULE4) internal clock-out mode: first pin I/O, second pin drives clock/4
// (RULE5) internal I/O mode: both oscillator pins are general I/O
// (RULE6) external clock input on first pin, second pin general I/O
// (RULE7) internal clock from 500 kHz reference, eight frequencies up to 16 MHz
// (RULE8) postscaler divides by one, two, four or eight
// (RULE9) multiplier bit locks source to 16 MHz ahead of postscaler
// (RULE10) multiplier bit is fixed at programming time by the programmer
// (RULE11) multiplier on: codes 11,10,01,00 give 16,8,4,2 MHz
// (RULE12) multiplier off: codes give 500,250,125,62.5 kHz
// (RULE13) every reset loads postscale select with binary 10
// (RULE14) new postscale selection applies with no start-up delay
// (RULE15) postscale select field sits at control bits five and four
// (RULE16) read-only bit three shows oscillator locked within two percent
// (RULE17) read-only bit two shows oscillator settled to half percent
// (RULE18) trim register holds six-bit two's complement value, reset zero
// (RULE19) trim 000000 calibrated, 011111 maximum, 100000 minimum frequency
// (RULE20) trim change moves frequency gradually, no completion indication
// (RULE21) crystal modes count 1024 first-pin oscillations before reset release
// (RULE22) mode encoding of the select field is chosen by this design
// (RULE23) unimplemented control and trim bits ignore writes, read zero
module scs_clock_select
   import scs_pkg::*;
#(
   parameter int STARTUP_OSC = SCS_STARTUP_OSC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [2:0]  first_configuration_word,
   input  wire logic        pll_multiplier_on,
   input  wire logic        first_oscillator_pin_in,
   output logic             first_oscillator_pin_oe,
   output logic             second_oscillator_pin_out,
   output logic             second_oscillator_pin_oe,
   output logic             int_clock_tick,
   output logic [5:0]       trim_applied,
   output logic             core_reset_n
);

   // configuration and pin inputs come from outside: two flops each, a third on the oscillator pin
   logic [2:0] cfg_s1_r;
   logic [2:0] cfg_s2_r;
   logic       pll_s1_r;
   logic       pll_s2_r;
   logic       osc_s1_r;
   logic       osc_s2_r;
   logic       osc_s3_r;

   // straps are static in use, but may move while reset is held
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_s1_r <= 3'h0;
         cfg_s2_r <= 3'h0;
      end else begin
         cfg_s1_r <= first_configuration_word;
         cfg_s2_r <= cfg_s1_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pll_s1_r <= 1'b0;
         pll_s2_r <= 1'b0;
      end else begin
         pll_s1_r <= pll_multiplier_on;
         pll_s2_r <= pll_s1_r;
      end
   end

   // third stage only feeds the edge detector, after the synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_s1_r <= 1'b0;
         osc_s2_r <= 1'b0;
         osc_s3_r <= 1'b0;
      end else begin
         osc_s1_r <= first_oscillator_pin_in;
         osc_s2_r <= osc_s1_r;
         osc_s3_r <= osc_s2_r;
      end
   end

   // (RULE22) own mode encoding
   scs_mode_t mode;
   assign mode = scs_mode_t'(cfg_s2_r);
   // (RULE10) multiplier taken as a static strap
   wire pll_on = pll_s2_r;

   // APB decode
   wire acc      = psel & penable;
   wire hit_ctl  = (paddr == SCS_ADDR_CONTROL);
   wire hit_trim = (paddr == SCS_ADDR_TRIM);
   wire hit_cfg  = (paddr == SCS_ADDR_CONFIG);
   wire mapped   = hit_ctl | hit_trim | hit_cfg;
   wire wr_ctl   = acc & pwrite & hit_ctl & ~pready;
   wire wr_trim  = acc & pwrite & hit_trim & ~pready;

   logic [1:0] postscale_select_r;
   logic [5:0] trim_value_r;
   logic       int_osc_locked_r;
   logic       int_osc_settled_r;

   // (RULE13) reset loads 10; (RULE15) field at bits 5:4
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         postscale_select_r <= SCS_PS_RESET;
      else if (wr_ctl)
         postscale_select_r <= pwdata[SCS_PS_LSB +: 2];
   end

   // (RULE18) six-bit trim, reset zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         trim_value_r <= SCS_TRIM_RESET;
      else if (wr_trim)
         trim_value_r <= pwdata[SCS_TRIM_W-1:0];
   end

   // (RULE23) unimplemented bits read zero
   logic [31:0] rd_mux;
   assign rd_mux =
      hit_ctl  ? {24'h000000, 2'h0, postscale_select_r,
                  int_osc_locked_r, int_osc_settled_r, 2'h0} :
      hit_trim ? {26'h0000000, trim_value_r} :
      hit_cfg  ? {28'h0000000, pll_on, cfg_s2_r} : 32'h00000000;

   // one wait state: ready one cycle into access phase
   wire        answer_due = acc & ~pready;
   wire [31:0] rd_word    = (answer_due & ~pwrite) ? rd_mux : 32'h00000000;

   // ready is a pulse, so a held access answers at most every second cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pready <= 1'b0;
      else
         pready <= answer_due;
   end

   // (RULE23) unmapped address answers with an error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pslverr <= 1'b0;
      else
         pslverr <= answer_due & ~mapped;
   end

   // read data stands only while ready stands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h00000000;
      else
         prdata <= rd_word;
   end

   // (RULE7) source divide; (RULE9) 16 MHz when multiplier on
   localparam int DIVW = 8;
   localparam logic [DIVW-1:0] PLL_LAST = DIVW'(SCS_PLL_DIV - 1);
   localparam logic [DIVW-1:0] REF_LAST = DIVW'(SCS_REF_DIV - 1);
   wire [DIVW-1:0] src_last = pll_on ? PLL_LAST : REF_LAST;
   logic [DIVW-1:0] src_cnt_r;
   logic            src_tick_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_cnt_r  <= '0;
         src_tick_r <= 1'b0;
      end else if (src_cnt_r >= src_last) begin
         src_cnt_r  <= '0;
         src_tick_r <= 1'b1;
      end else begin
         src_cnt_r  <= src_cnt_r + DIVW'(1);
         src_tick_r <= 1'b0;
      end
   end

   // (RULE8) postscaler 1/2/4/8; (RULE11) (RULE12) code 11 = undivided
   logic [2:0] ps_cnt_r;
   logic [2:0] ps_mask;
   always_comb begin
      unique case (postscale_select_r)
         2'b11: ps_mask = 3'h0;
         2'b10: ps_mask = 3'h1;
         2'b01: ps_mask = 3'h3;
         2'b00: ps_mask = 3'h7;
      endcase
   end
   // (RULE14) mux select acts at once, no restart delay
   wire ps_tick = src_tick_r & ((ps_cnt_r & ps_mask) == 3'h0);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ps_cnt_r <= 3'h0;
      else if (src_tick_r)
         ps_cnt_r <= ps_cnt_r + 3'h1;
   end

   // internal clock level toggles per tick
   // clock-out counts whole internal periods, so only rising ticks count
   logic       int_clk_r;
   logic [1:0] q_cnt_r;
   wire        int_rise = ps_tick & ~int_clk_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_clk_r      <= 1'b0;
         q_cnt_r        <= 2'h0;
         int_clock_tick <= 1'b0;
      end else begin
         int_clock_tick <= ps_tick;
         if (ps_tick)
            int_clk_r <= ~int_clk_r;
         if (int_rise)
            q_cnt_r <= q_cnt_r + 2'h1;
      end
   end

   // external RC: one first-pin rising edge per oscillator period
   wire        osc_rise = osc_s2_r & ~osc_s3_r;
   logic [1:0] ext_cnt_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ext_cnt_r <= 2'h0;
      else if (osc_rise)
         ext_cnt_r <= ext_cnt_r + 2'h1;
   end

   // (RULE1) mode decides pin use
   wire is_int_out = (mode == SCS_MODE_INT_RC_CLOCK_OUT);
   wire is_ext_rc  = (mode == SCS_MODE_EXT_RC_CLOCK_OUT);
   wire is_xtal    = (mode == SCS_MODE_LOW_POWER_CRYSTAL) |
                     (mode == SCS_MODE_MEDIUM_GAIN_RESON) |
                     (mode == SCS_MODE_HIGH_GAIN_RESON);
   // (RULE4) internal /4 on second pin
   // (RULE2) external RC /4 on second pin
   wire pin2_out_nxt = is_int_out ? q_cnt_r[1] :
                       is_ext_rc  ? ext_cnt_r[1] : 1'b0;
   // (RULE3) (RULE5) (RULE6) second pin released otherwise
   wire pin2_oe_nxt  = is_int_out | is_ext_rc;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         second_oscillator_pin_out <= 1'b0;
      else
         second_oscillator_pin_out <= pin2_out_nxt;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         second_oscillator_pin_oe <= 1'b0;
      else
         second_oscillator_pin_oe <= pin2_oe_nxt;
   end

   // first pin is input or free I/O; never driven by this block
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         first_oscillator_pin_oe <= 1'b0;
      else
         first_oscillator_pin_oe <= 1'b0;
   end

   // (RULE21) crystal start-up counter
   localparam int SUW = $clog2(STARTUP_OSC + 1);
   localparam logic [SUW-1:0] SU_LAST = SUW'(STARTUP_OSC);
   scs_state_t st_r;
   logic [SUW-1:0] su_cnt_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r         <= SCS_ST_COUNT;
         su_cnt_r     <= '0;
         core_reset_n <= 1'b0;
      end else begin
         unique case (st_r)
            SCS_ST_COUNT: begin
               if (!is_xtal || su_cnt_r == SU_LAST) begin
                  st_r         <= SCS_ST_RUN;
                  core_reset_n <= 1'b1;
               end else if (osc_rise)
                  su_cnt_r <= su_cnt_r + SUW'(1);
            end
            SCS_ST_RUN: core_reset_n <= 1'b1;
            default: st_r <= SCS_ST_COUNT;
         endcase
      end
   end

   // (RULE20) trim slews one step per internal tick, silently
   // (RULE19) signed compare orders codes min to max
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         trim_applied <= SCS_TRIM_RESET;
      else if (ps_tick) begin
         if ($signed(trim_applied) < $signed(trim_value_r))
            trim_applied <= trim_applied + 6'h01;
         else if ($signed(trim_applied) > $signed(trim_value_r))
            trim_applied <= trim_applied - 6'h01;
      end
   end

   // (RULE16) (RULE17) lock then settle timers after reset
   localparam logic [8:0] LOCK_LAST = 9'(SCS_LOCK_CYCLES);
   localparam logic [8:0] SETL_LAST = 9'(SCS_SETTLE_CYCLES);
   logic [8:0] st_cnt_r;
   // counter parks at the settle count so the flags never fall again
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         st_cnt_r <= 9'h000;
      else if (st_cnt_r != SETL_LAST)
         st_cnt_r <= st_cnt_r + 9'h001;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_osc_locked_r  <= 1'b0;
         int_osc_settled_r <= 1'b0;
      end else begin
         int_osc_locked_r  <= (st_cnt_r >= LOCK_LAST);
         int_osc_settled_r <= (st_cnt_r == SETL_LAST);
      end
   end

endmodule : scs_clock_select

/* File: test/scs_osc_model.sv */
`timescale 1ns/1ns
module scs_osc_model (
   input  wire logic pclk,
   input  wire logic run,
   output logic      osc
);
   logic [1:0] cnt_r;
   // crystal sits low until started, never free running
   always_ff @(posedge pclk) begin
      cnt_r <= (cnt_r == 2'h2 || !run) ? 2'h0 : cnt_r + 2'h1;
      if (!run) osc <= 1'b0;
      else if (cnt_r == 2'h2) osc <= ~osc;
   end
endmodule : scs_osc_model

/* File: test/scs_clock_select_asserts.sv */
`timescale 1ns/1ns
module scs_clock_select_asserts
   import scs_pkg::*;
#(
   parameter int STARTUP_OSC = SCS_STARTUP_OSC
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [2:0]  first_configuration_word,
   input wire logic        pll_multiplier_on,
   input wire logic        first_oscillator_pin_in,
   input wire logic        first_oscillator_pin_oe,
   input wire logic        second_oscillator_pin_out,
   input wire logic        second_oscillator_pin_oe,
   input wire logic        int_clock_tick,
   input wire logic [5:0]  trim_applied,
   input wire logic        core_reset_n
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence wait_s;
      psel && penable && !pready;
   endsequence
   wire rd_ctl = pready && !pwrite && paddr == SCS_ADDR_CONTROL;

   apb_wait_a: assert property (setup_s ##1 wait_s |=> pready)
      else $error("answer not one wait state late");
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than a cycle");
   err_pulse_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   ctrl_pad_a: assert property (rd_ctl |-> prdata[31:6] == 26'h0
      && prdata[1:0] == 2'h0) else $error("control spare bits set");
   trim_pad_a: assert property (pready && paddr == SCS_ADDR_TRIM
      |-> prdata[31:6] == 26'h0) else $error("trim spare bits set");
   settle_order_a: assert property (rd_ctl && prdata[2] |-> prdata[3])
      else $error("settled before locked");
   pin1_input_a: assert property (!first_oscillator_pin_oe)
      else $error("first pin driven");
   pin2_mode_a: assert property (second_oscillator_pin_oe
      |-> first_configuration_word inside {3'h5, 3'h7})
      else $error("second pin driven in io mode");
   trim_slew_a: assert property (!$stable(trim_applied)
      |-> trim_applied - $past(trim_applied) inside {6'h01, 6'h3F})
      else $error("trim jumped");
endmodule : scs_clock_select_asserts

bind scs_clock_select scs_clock_select_asserts #(.STARTUP_OSC(STARTUP_OSC))
   chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr),
   .first_configuration_word(first_configuration_word),
   .pll_multiplier_on(pll_multiplier_on),
   .first_oscillator_pin_in(first_oscillator_pin_in),
   .first_oscillator_pin_oe(first_oscillator_pin_oe),
   .second_oscillator_pin_out(second_oscillator_pin_out),
   .second_oscillator_pin_oe(second_oscillator_pin_oe),
   .int_clock_tick(int_clock_tick), .trim_applied(trim_applied),
   .core_reset_n(core_reset_n));

/* File: test/scs_clock_select_tb.sv */
`timescale 1ns/1ns
module scs_clock_select_tb
   import scs_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pll, run, er, o;
   logic        pready, pslverr, osc, oe1, out2, oe2, tick, crst_n;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  mode;
   logic [5:0]  trim;
   int          mismatches, tests_run, n, k, g;

   scs_clock_select #(.STARTUP_OSC(8)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .first_configuration_word(mode), .pll_multiplier_on(pll),
      .first_oscillator_pin_in(osc), .first_oscillator_pin_oe(oe1),
      .second_oscillator_pin_out(out2), .second_oscillator_pin_oe(oe2),
      .int_clock_tick(tick), .trim_applied(trim), .core_reset_n(crst_n));
   scs_osc_model osc_i (.pclk(pclk), .run(run), .osc(osc));

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task finish_test;
      if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         mismatches++;
      end
   endtask : chk

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rst(input logic [2:0] m, input logic p);
      @(posedge pclk);
      presetn <= 1'b0;
      mode <= m;
      pll <= p;
      run <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask : rst

   task wait_tick;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (tick !== 1'b1 && n < 5000);
   endtask : wait_tick

   task tick_rates(input logic p);
      rst(3'h4, p);
      for (int c = 3; c >= 0; c--) begin
         apb(1'b1, SCS_ADDR_CONTROL, c << 4);
         apb(1'b0, SCS_ADDR_CONTROL, 32'h0);
         chk("ps", c, rd[5:4]);
         wait_tick;
         wait_tick;
         wait_tick;
         chk("tick", (p ? SCS_PLL_DIV : SCS_REF_DIV) << (3 - c), n);
      end
   endtask : tick_rates

   task modes;
      for (int m = 0; m < 8; m++) begin
         rst(m[2:0], 1'b1);
         repeat (30) @(posedge pclk);
         chk("crst", m > 2, crst_n);
         run <= 1'b1;
         repeat (100) @(posedge pclk);
         chk("crst2", 1, crst_n);
         chk("oe2", m == 5 || m == 7, oe2);
         apb(1'b0, SCS_ADDR_CONFIG, 32'h0);
         chk("cfg", m | 8, rd);
         n = 0;
         k = 0;
         g = 0;
         o = out2;
         repeat (300) begin
            @(posedge pclk);
            k++;
            if (out2 !== o) begin
               n++;
               if (n == 2) g = k;
               k = 0;
            end
            o = out2;
         end
         chk("clkout", m == 5 || m == 7, n > 0);
         // half period of /4: two internal periods, or two model periods
         chk("div4", m == 5 ? SCS_PLL_DIV * 8 : m == 7 ? 12 : 0, g);
      end
   endtask : modes

   task regs;
      rst(3'h4, 1'b1);
      apb(1'b0, SCS_ADDR_CONTROL, 32'h0);
      chk("ctl", 32'h20, rd & 32'hFFFFFFF3);
      repeat (300) @(posedge pclk);
      apb(1'b1, SCS_ADDR_CONTROL, 32'hFFFFFFFF);
      apb(1'b0, SCS_ADDR_CONTROL, 32'h0);
      chk("ctl2", 32'h3C, rd);
      apb(1'b0, SCS_ADDR_TRIM, 32'h0);
      chk("trim0", 0, rd);
      apb(1'b1, SCS_ADDR_TRIM, 32'hFFFFFFE0);
      apb(1'b0, SCS_ADDR_TRIM, 32'h0);
      chk("trim1", 32'h20, rd);
      n = 0;
      while (trim !== 6'h20 && n < 5000) begin
         @(posedge pclk);
         n++;
      end
      chk("slew", 32'h20, trim);
      apb(1'b1, 12'h00C, 32'h10);
      chk("err", 1, er);
      apb(1'b0, 12'h00C, 32'h0);
      chk("unm", 0, rd);
   endtask : regs

   initial begin
      {psel, penable, pwrite, presetn, pll, run} = 6'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      mode = 3'h0;
      mismatches = 0;
      tests_run = 0;
      regs;
      modes;
      tick_rates(1'b1);
      tick_rates(1'b0);
      finish_test;
   end

   initial begin
      #200000;
      mismatches++;
      finish_test;
   end
endmodule : scs_clock_select_tb
